// File: rtl/pbsp_array.sv
// Storage array with per-lane write
`timescale 1ns/1ps
module pbsp_array #(
  parameter int AW    = 20,
  parameter int LANES = 4,
  parameter int LW    = 9
) (
  input  wire logic clk_i,
  pbsp_mem_if.mem   mem
);
  logic [LANES*LW-1:0] store [0:(1<<AW)-1];

  // Lane-masked write, unselected lanes untouched
  always_ff @(posedge clk_i) begin
    for (int l = 0; l < LANES; l++) begin
      if (mem.we && mem.lane_we[l]) begin
        store[mem.addr][l*LW +: LW] <= mem.wdata[l*LW +: LW];
      end
    end
  end

  assign mem.rdata = store[mem.addr];
endmodule

// File: rtl/pbsp_cfg.svh
// Constants for the pipelined burst SRAM port
// Summary of operation
// - Selected when first low, second high, third low
// - Chip selects sampled only on address load
// - Processor strobe ignored while first select high
// - Strobe low captures address, seeds burst counter
// - Both strobes low: processor strobe wins
// - Step low during burst advances address
// - Two-bit wrapping burst counter from first address
// - Order select low linear, high interleaved
// - Linear adds one; interleaved XORs step count
// - Output enable low drives, high tristates
// - First read cycle after deselect stays tristated
// - Data outputs and all inputs but output enable registered on rising edge
// - Input data captured on rising edge
// - Read: strobe, selected, both writes high
// - Read data appears one cycle after capture
// - Back-to-back single reads accepted
// - Outputs drive one more cycle after deselect
// - Byte writes only on selected lanes
// - Global write writes all four bytes
// - Sleep input holds state, data preserved
// - Sleep entry and exit take two cycles
// - Data outputs tristated during write cycles
`ifndef PBSP_CFG_SVH
`define PBSP_CFG_SVH
`define PBSP_ADDR_W    20
`define PBSP_LANES     4
`define PBSP_LANE_W    9
`define PBSP_SLEEP_CYC 2
`define PBSP_SEED_W    2
`endif

// File: rtl/pbsp_mem_if.sv
// Array access bundle between the port logic and the storage array
`timescale 1ns/1ps
interface pbsp_mem_if #(
  parameter int AW    = 20,
  parameter int LANES = 4,
  parameter int LW    = 9
);
  logic [AW-1:0]       addr;
  logic                we;
  logic [LANES-1:0]    lane_we;
  logic [LANES*LW-1:0] wdata;
  logic [LANES*LW-1:0] rdata;
  modport ctrl (output addr, output we, output lane_we, output wdata, input rdata);
  modport mem  (input addr, input we, input lane_we, input wdata, output rdata);
endinterface

// File: rtl/pbsp_pkg.sv
// Types for the pipelined burst SRAM port
package pbsp_pkg;
  typedef enum logic [1:0] {
    PBSP_IDLE  = 2'b00,
    PBSP_READ  = 2'b01,
    PBSP_WRITE = 2'b10
  } pbsp_op_t;
  typedef enum logic [1:0] {
    PBSP_AWAKE   = 2'b00,
    PBSP_ENTER   = 2'b01,
    PBSP_ASLEEP  = 2'b10,
    PBSP_RECOVER = 2'b11
  } pbsp_sleep_t;
endpackage

// File: rtl/pbsp_port.sv
// Pipelined double-cycle-deselect burst SRAM port
`timescale 1ns/1ps
`include "pbsp_cfg.svh"
module pbsp_port #(
  parameter int AW    = `PBSP_ADDR_W,
  parameter int LANES = `PBSP_LANES,
  parameter int LW    = `PBSP_LANE_W
) (
  input  wire logic                clk_i,
  input  wire logic                rstn_i,
  input  wire logic [AW-1:0]       addr_i,
  input  wire logic                select_low_first_n_i,
  input  wire logic                select_high_second_i,
  input  wire logic                select_low_third_n_i,
  input  wire logic                processor_addr_strobe_n_i,
  input  wire logic                controller_addr_strobe_n_i,
  input  wire logic                burst_step_n_i,
  input  wire logic                all_bytes_write_n_i,
  input  wire logic                lane_write_enable_n_i,
  input  wire logic [LANES-1:0]    lane_select_n_i,
  input  wire logic                output_enable_n_i,
  input  wire logic                sleep_request_i,
  input  wire logic                burst_order_i,
  input  wire logic [LANES*LW-1:0] data_i,
  output logic      [LANES*LW-1:0] data_o,
  output logic      [LANES*LW-1:0] data_oe_o,
  output logic                     asleep_o
);
  localparam int SW = `PBSP_SEED_W;

  // State of the port apart from the registered input samples
  typedef struct packed {
    logic [AW-1:0]       addr;
    logic [SW-1:0]       seed;
    logic [SW-1:0]       step;
    logic                active;
    logic                wr_pend;
    logic [AW-1:0]       wr_addr;
    pbsp_pkg::pbsp_op_t  op;
    logic                drive;
    logic                mask_first;
    logic [LANES*LW-1:0] dout;
    pbsp_pkg::pbsp_sleep_t sl;
    logic [1:0]          sl_cnt;
    logic                order;
  } pbsp_state_t;

  pbsp_state_t s;
  pbsp_state_t next_s;

  // Registered input samples
  logic [AW-1:0]       r_addr;
  logic                r_ce1_n;
  logic                r_ce2;
  logic                r_ce3_n;
  logic                r_sp_n;
  logic                r_sc_n;
  logic                r_adv_n;
  logic                r_gw_n;
  logic                r_bwe_n;
  logic [LANES-1:0]    r_bw_n;
  logic [LANES*LW-1:0] r_din;
  logic                r_zz;

  pbsp_mem_if #(.AW(AW), .LANES(LANES), .LW(LW)) mif ();

  pbsp_array #(.AW(AW), .LANES(LANES), .LW(LW)) u_array (
    .clk_i (clk_i),
    .mem   (mif.mem)
  );

  // Burst address from seed and step count
  function automatic logic [SW-1:0] burst_addr(input logic [SW-1:0] seed,
                                               input logic [SW-1:0] step,
                                               input logic          ilv);
    burst_addr = ilv ? (seed ^ step) : SW'(seed + step);
  endfunction

  // Input registers on the rising edge
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r_addr  <= '0;
      r_ce1_n <= 1'b1;
      r_ce2   <= 1'b0;
      r_ce3_n <= 1'b1;
      r_sp_n  <= 1'b1;
      r_sc_n  <= 1'b1;
      r_adv_n <= 1'b1;
      r_gw_n  <= 1'b1;
      r_bwe_n <= 1'b1;
      r_bw_n  <= '1;
      r_din   <= '0;
      r_zz    <= 1'b0;
    end else begin
      r_addr  <= addr_i;
      r_ce1_n <= select_low_first_n_i;
      r_ce2   <= select_high_second_i;
      r_ce3_n <= select_low_third_n_i;
      r_sp_n  <= processor_addr_strobe_n_i;
      r_sc_n  <= controller_addr_strobe_n_i;
      r_adv_n <= burst_step_n_i;
      r_gw_n  <= all_bytes_write_n_i;
      r_bwe_n <= lane_write_enable_n_i;
      r_bw_n  <= lane_select_n_i;
      r_din   <= data_i;
      r_zz    <= sleep_request_i;
    end
  end

  // Decoded controls of the sampled cycle
  logic             selected;
  logic             sp_take;
  logic             sc_take;
  logic             load;
  logic             wr_any;
  logic [LANES-1:0] lanes;
  logic             awake;

  assign awake    = (s.sl == pbsp_pkg::PBSP_AWAKE);
  assign selected = !r_ce1_n && r_ce2 && !r_ce3_n;
  assign sp_take  = !r_sp_n && !r_ce1_n;
  assign sc_take  = !r_sc_n && r_sp_n;
  assign load     = awake && (sp_take || sc_take);
  assign lanes    = !r_gw_n ? '1 :
                    (!r_bwe_n ? ~r_bw_n : '0);
  assign wr_any   = |lanes;

  // Next-state logic for addressing, writes, output control and sleep
  always_comb begin
    next_s         = s;
    mif.we         = 1'b0;
    mif.lane_we    = '0;
    mif.wdata      = r_din;
    mif.addr       = {s.addr[AW-1:SW], burst_addr(s.seed, s.step, s.order)};
    next_s.wr_pend = 1'b0;
    next_s.order   = burst_order_i;
    if (load) begin
      // New address, chip selects sampled here only
      next_s.addr   = r_addr;
      next_s.seed   = r_addr[SW-1:0];
      next_s.step   = '0;
      next_s.active = selected;
      mif.addr      = r_addr;
      if (!selected) begin
        next_s.op = pbsp_pkg::PBSP_IDLE;
      end else if (sp_take) begin
        // Processor strobe: write controls taken next cycle
        next_s.op      = pbsp_pkg::PBSP_READ;
        next_s.wr_pend = 1'b1;
      end else if (wr_any) begin
        next_s.op   = pbsp_pkg::PBSP_WRITE;
        mif.we      = 1'b1;
        mif.lane_we = lanes;
      end else begin
        next_s.op = pbsp_pkg::PBSP_READ;
      end
    end else if (awake && s.active) begin
      if (s.wr_pend && wr_any) begin
        // Second cycle of a processor-strobe write
        next_s.op   = pbsp_pkg::PBSP_WRITE;
        mif.we      = 1'b1;
        mif.lane_we = lanes;
      end else if (!r_adv_n) begin
        next_s.step = SW'(s.step + 1'b1);
        mif.addr    = {s.addr[AW-1:SW], burst_addr(s.seed, SW'(s.step + 1'b1), s.order)};
        if (wr_any) begin
          next_s.op   = pbsp_pkg::PBSP_WRITE;
          mif.we      = 1'b1;
          mif.lane_we = lanes;
        end else begin
          next_s.op = pbsp_pkg::PBSP_READ;
        end
      end else if (wr_any) begin
        next_s.op   = pbsp_pkg::PBSP_WRITE;
        mif.we      = 1'b1;
        mif.lane_we = lanes;
      end else begin
        next_s.op = pbsp_pkg::PBSP_READ;
      end
    end
    // Output register loads array data one cycle after capture
    if (next_s.op == pbsp_pkg::PBSP_READ) begin
      next_s.dout = mif.rdata;
    end
    // Deselect keeps drive one more cycle first read masked
    next_s.mask_first = (next_s.op == pbsp_pkg::PBSP_READ) && !s.drive;
    next_s.drive      = (next_s.op == pbsp_pkg::PBSP_READ) ||
                        (s.op == pbsp_pkg::PBSP_READ && next_s.op == pbsp_pkg::PBSP_IDLE);
    // Sleep sequencing over two cycles each way
    case (s.sl)
      pbsp_pkg::PBSP_AWAKE: begin
        if (r_zz) begin
          next_s.sl     = pbsp_pkg::PBSP_ENTER;
          next_s.sl_cnt = 2'(`PBSP_SLEEP_CYC - 1);
        end
      end
      pbsp_pkg::PBSP_ENTER: begin
        next_s.op     = pbsp_pkg::PBSP_IDLE;
        next_s.active = 1'b0;
        next_s.drive  = 1'b0;
        if (s.sl_cnt == 2'h1) begin
          next_s.sl = pbsp_pkg::PBSP_ASLEEP;
        end else begin
          next_s.sl_cnt = 2'(s.sl_cnt - 1'b1);
        end
      end
      pbsp_pkg::PBSP_ASLEEP: begin
        next_s.drive = 1'b0;
        if (!r_zz) begin
          next_s.sl     = pbsp_pkg::PBSP_RECOVER;
          next_s.sl_cnt = 2'(`PBSP_SLEEP_CYC - 1);
        end
      end
      pbsp_pkg::PBSP_RECOVER: begin
        next_s.drive = 1'b0;
        if (s.sl_cnt == 2'h1) begin
          next_s.sl = pbsp_pkg::PBSP_AWAKE;
        end else begin
          next_s.sl_cnt = 2'(s.sl_cnt - 1'b1);
        end
      end
      default: begin
        next_s.sl = pbsp_pkg::PBSP_AWAKE;
      end
    endcase
  end

  // Single state register; burst order strap follows its pin
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= '{addr: '0, seed: '0, step: '0, active: 1'b0, wr_pend: 1'b0,
             wr_addr: '0, op: pbsp_pkg::PBSP_IDLE, drive: 1'b0,
             mask_first: 1'b0, dout: '0, sl: pbsp_pkg::PBSP_AWAKE,
             sl_cnt: 2'h0, order: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  // Output enable is asynchronous; writes force tristate
  logic oe_now;
  assign oe_now    = s.drive && !s.mask_first && !output_enable_n_i &&
                     (s.op != pbsp_pkg::PBSP_WRITE);
  assign data_o    = s.dout;
  assign data_oe_o = {(LANES*LW){oe_now}};
  assign asleep_o  = (s.sl == pbsp_pkg::PBSP_ASLEEP);

  // Checks
  chk_sp_ignored: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (r_ce1_n && r_sc_n && awake) |=> $stable(s.addr)) else $error("strobe taken");
  chk_load_seed: assert property (@(posedge clk_i) disable iff (!rstn_i)
    load |=> (s.seed == $past(r_addr[SW-1:0]) && s.step == 2'h0))
    else $error("seed not loaded");
  chk_sel_decode: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (load && !selected) |=> !s.active) else $error("bad select");
  chk_step_wrap: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!load && awake && s.active && !s.wr_pend && !r_adv_n) |=>
    s.step == 2'($past(s.step) + 1'b1)) else $error("step not advanced");
  chk_write_tri: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (s.op == pbsp_pkg::PBSP_WRITE) |-> !oe_now) else $error("driving in write");
  chk_first_mask: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!s.drive ##1 s.op == pbsp_pkg::PBSP_READ) |-> !oe_now)
    else $error("first read driven");
  chk_dcd_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (awake && s.op == pbsp_pkg::PBSP_READ && load && !selected) |=> s.drive)
    else $error("deselect too early");
  chk_sleep_two: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (s.sl == pbsp_pkg::PBSP_AWAKE && r_zz) |=> ##1 s.sl == pbsp_pkg::PBSP_ASLEEP)
    else $error("sleep entry timing");
  chk_oe_follow: assert property (@(posedge clk_i) disable iff (!rstn_i)
    output_enable_n_i |-> !oe_now) else $error("drive with oe high");
  cov_read: cover property (@(posedge clk_i) disable iff (!rstn_i)
    load && selected && !wr_any ##1 oe_now);
  cov_burst: cover property (@(posedge clk_i) disable iff (!rstn_i)
    s.step == 2'h3);
  cov_write: cover property (@(posedge clk_i) disable iff (!rstn_i) mif.we);
  cov_sleep: cover property (@(posedge clk_i) disable iff (!rstn_i) asleep_o);
endmodule

// File: verif/pbsp_host_model.sv
// Host bus model driving the pipelined burst SRAM port
`timescale 1ns/1ps
module pbsp_host_model #(
  parameter int AW = 20,
  parameter int DW = 36
) (
  input  wire logic          clk_i,
  input  wire logic [DW-1:0] data_o,
  input  wire logic [DW-1:0] data_oe_o,
  output logic      [2:0]    sel_o,
  output logic      [1:0]    stb_n_o,
  output logic               step_n_o,
  output logic      [1:0]    wr_n_o,
  output logic      [3:0]    lane_n_o,
  output logic      [AW-1:0] addr_o,
  output logic               oe_n_o,
  output logic               sleep_o,
  output logic               order_o,
  output logic      [DW-1:0] bus_o
);
  logic [DW-1:0] wd_q;
  logic [DW-1:0] last_q = '0;
  logic          drv_q;
  logic          oe_off = 1'b0;
  // Shared data wire: device, host, or a changing pattern once released
  assign bus_o = data_oe_o[0] ? data_o : (drv_q ? wd_q : ~last_q);
  always @(posedge clk_i) last_q <= bus_o;
  // Idle bus at time zero, device deselected
  initial begin
    {sel_o, stb_n_o, step_n_o, wr_n_o, lane_n_o} = 12'hFFF;
    addr_o = '0;
    oe_n_o = 1'b1;
    sleep_o = 1'b0;
    order_o = 1'b1;
    wd_q = '0;
    drv_q = 1'b0;
  end
  // One bus cycle; all request signals change just after the edge
  task automatic put(input logic [2:0] s, input logic [1:0] b, input logic st,
                     input logic [1:0] w, input logic [3:0] l, input logic [AW-1:0] a,
                     input logic [DW-1:0] d, input logic dr);
    @(posedge clk_i);
    sel_o    <= s;
    stb_n_o  <= b;
    step_n_o <= st;
    wr_n_o   <= w;
    lane_n_o <= l;
    addr_o   <= a;
    wd_q     <= d;
    drv_q    <= dr;
    oe_n_o   <= dr | oe_off;  // output enable off while write data is driven
  endtask
  // Cycle with both strobes inactive
  task automatic idle(input logic st);
    put(3'h2, 2'b11, st, 2'b11, 4'hF, addr_o, '0, 1'b0);
  endtask
  // Strap change only while deselected and quiet
  task automatic strap(input logic m);
    put(3'h6, 2'b01, 1'b1, 2'b11, 4'hF, addr_o, '0, 1'b0);
    order_o <= m;
    repeat (3) @(posedge clk_i);
  endtask
  // Deselect, then request sleep
  task automatic nap(input int n);
    put(3'h6, 2'b01, 1'b1, 2'b11, 4'hF, addr_o, '0, 1'b0);
    put(3'h7, 2'b11, 1'b1, 2'b11, 4'hF, addr_o, '0, 1'b0);
    sleep_o <= 1'b1;
    repeat (n) @(posedge clk_i);
  endtask
  // Leave sleep with strobes and selects inactive during recovery
  task automatic wake(input int n);
    @(posedge clk_i);
    sleep_o <= 1'b0;
    repeat (n) @(posedge clk_i);
  endtask
endmodule

// File: verif/pipelined_burst_sram_port_tb_top.sv
// Self-checking bench for the pipelined burst SRAM port
`timescale 1ns/1ps
module pipelined_burst_sram_port_tb_top;
  localparam logic [19:0] BASE = 20'h00120;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [2:0]  sel;
  logic [1:0]  stb_n;
  logic        step_n;
  logic [1:0]  wr_n;
  logic [3:0]  lane_n;
  logic [19:0] addr;
  logic        oe_n;
  logic        sleep;
  logic        order;
  logic [35:0] bus;
  logic [35:0] data_o;
  logic [35:0] data_oe_o;
  logic        asleep_o;
  logic [35:0] ex [4];
  logic [2:0]  bad [3] = '{3'h0, 3'h3, 3'h6};
  int          failures = 0;
  int          n_checks = 0;
  int          cyc = 0;
  initial forever #4 clk_i = ~clk_i;
  pbsp_host_model h (.clk_i(clk_i), .data_o(data_o), .data_oe_o(data_oe_o), .sel_o(sel),
    .stb_n_o(stb_n), .step_n_o(step_n), .wr_n_o(wr_n), .lane_n_o(lane_n), .addr_o(addr),
    .oe_n_o(oe_n), .sleep_o(sleep), .order_o(order), .bus_o(bus));
  pbsp_port dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr),
    .select_low_first_n_i(sel[2]), .select_high_second_i(sel[1]),
    .select_low_third_n_i(sel[0]), .processor_addr_strobe_n_i(stb_n[0]),
    .controller_addr_strobe_n_i(stb_n[1]), .burst_step_n_i(step_n),
    .all_bytes_write_n_i(wr_n[1]), .lane_write_enable_n_i(wr_n[0]),
    .lane_select_n_i(lane_n), .output_enable_n_i(oe_n), .sleep_request_i(sleep),
    .burst_order_i(order), .data_i(bus), .data_o(data_o), .data_oe_o(data_oe_o),
    .asleep_o(asleep_o));
  // Compare and count
  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Write cycle; data held one extra cycle
  task automatic wr(input logic [19:0] a, input logic [35:0] d, input logic [3:0] l,
                    input logic [1:0] w, input logic [1:0] b, input logic [2:0] s);
    h.put(s, b, 1'b1, w, l, a, d, 1'b1);
    h.put(3'h2, 2'b11, 1'b1, 2'b11, 4'hF, a, d, 1'b1);
    h.idle(1'b1);
  endtask
  // Single read; data settles after the second edge past the load
  task automatic rd(input logic [19:0] a, input logic [35:0] e);
    h.put(3'h2, 2'b01, 1'b1, 2'b11, 4'hF, a, '0, 1'b0);
    h.idle(1'b1);
    repeat (2) @(posedge clk_i);
    #1;
    check("read data", data_o, e);
  endtask
  // Four-beat burst read; selects toggled mid-burst must be ignored
  task automatic burst(input logic [19:0] a);
    logic [1:0] i;
    h.put(3'h2, 2'b01, 1'b1, 2'b11, 4'hF, a, '0, 1'b0);
    for (int k = 0; k < 6; k++) begin
      h.put(3'h0, 2'b11, k == 0 || k > 3, 2'b11, 4'hF, a, '0, 1'b0);
      #1;
      i = order ? a[1:0] ^ 2'(k - 2) : a[1:0] + 2'(k - 2);
      if (k > 1) check("burst data", data_o, ex[i]);
    end
  endtask
  // Verdict and end of run
  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      results();
    end
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int j = 0; j < 4; j++) begin
      ex[j] = {32'h5A5A_0000, 4'(j)};
      wr(BASE + 20'(j), ex[j], 4'hA, 2'b00, 2'b01, 3'h2);
    end
    wr(BASE + 20'h1, '1, 4'hE, 2'b10, 2'b01, 3'h2);
    ex[1][8:0] = 9'h1FF;
    rd(BASE + 20'h1, ex[1]);
    h.put(3'h2, 2'b01, 1'b1, 2'b11, 4'hF, BASE, '0, 1'b0);
    h.put(3'h2, 2'b10, 1'b1, 2'b11, 4'hF, BASE + 20'h2, '0, 1'b0);
    h.idle(1'b1);
    #1;
    check("first data", data_o, ex[0]);
    @(posedge clk_i);
    #1;
    check("second data", data_o, ex[2]);
    check("data enable on", data_oe_o, '1);
    h.oe_off = 1'b1;
    rd(BASE + 20'h3, ex[3]);
    check("data enable off", data_oe_o, '0);
    h.oe_off = 1'b0;
    burst(BASE + 20'h1);
    h.strap(1'b0);
    burst(BASE + 20'h3);
    wr(BASE, 36'h0_0BAD_0000, 4'h0, 2'b00, 2'b01, 3'h6);
    foreach (bad[n]) wr(BASE, 36'h0_0BAD_0000, 4'h0, 2'b00, 2'b10, bad[n]);
    wr(BASE, 36'h0_0BAD_0000, 4'h0, 2'b00, 2'b00, 3'h2);
    rd(BASE, ex[0]);
    h.nap(6);
    #1;
    check("asleep", {35'h0, asleep_o}, 36'h1);
    h.wake(6);
    #1;
    check("awake", {35'h0, asleep_o}, 36'h0);
    rd(BASE + 20'h1, ex[1]);
    results();
  end
endmodule
